// ==== hw/csp_ctrl.sv ====
// The APB slave port was left to the implementer.
`default_nettype none
module csp_ctrl #(
    parameter int unsigned SETTLE_CYC_0 = csp_pkg::SETTLE_CYC_0,
    parameter int unsigned SETTLE_CYC_1 = csp_pkg::SETTLE_CYC_1,
    parameter int unsigned SETTLE_CYC_2 = csp_pkg::SETTLE_CYC_2,
    parameter int unsigned SETTLE_CYC_3 = csp_pkg::SETTLE_CYC_3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_entry,
    input wire csp_pkg::csp_osc_stat_type osc_status,
    output var csp_pkg::csp_osc_ctrl_type osc_ctrl,
    output var csp_pkg::csp_clk_cfg_type clk_cfg
);
    csp_pkg::csp_osc_stat_type st;
    csp_pkg::csp_settle_type settle_r;
    csp_pkg::csp_settle_type settle_nxt;
    logic pll_on_r, mon_r, byp_r, fx_on_r, awon_r, rc_on_r, gate_r, src_r, fxf_r, lxf_r, xclk_prev_r;
    logic [1:0] drv_r, rcdiv_r, settle_sel_r, pdiv_r;
    logic [2:0] codiv_r, cosrc_r, apb2_r, apb1_r, ahb_r, sws_r, sw_r, n_r;
    logic [4:0] m_r;
    logic [5:0] ier_r, rdyf_r, rdy_prev_r;
    logic [14:0] cnt_r;
    logic pll_on_nxt, fx_on_nxt, rc_on_nxt, mon_nxt, byp_nxt;
    logic [2:0] sws_nxt;
    logic [5:0] rdyf_nxt;

    // Oscillator status pins come from the analog side
    csp_sync3 #(
        .WIDTH(7)
    ) u_sync (
        .clock(clock),
        .rstn(rstn),
        .din(osc_status),
        .dout(st)
    );

    // Bus decode
    logic setup, wr_go, mapped;
    logic sel_osc, sel_stab, sel_cfg, sel_pll, sel_ier, sel_isr, sel_icr;
    logic wr_osc, wr_stab, wr_cfg, wr_pll, wr_ier, wr_icr, pll_locked;
    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pready & pwrite;
    assign sel_osc = paddr == csp_pkg::OFF_OSC;
    assign sel_stab = paddr == csp_pkg::OFF_STAB;
    assign sel_cfg = paddr == csp_pkg::OFF_CFG;
    assign sel_pll = paddr == csp_pkg::OFF_PLL;
    assign sel_ier = paddr == csp_pkg::OFF_IER;
    assign sel_isr = paddr == csp_pkg::OFF_ISR;
    assign sel_icr = paddr == csp_pkg::OFF_ICR;
    assign mapped = sel_osc | sel_stab | sel_cfg | sel_pll | sel_ier | sel_isr | sel_icr;
    assign wr_osc = wr_go & sel_osc;
    assign wr_stab = wr_go & sel_stab;
    assign wr_cfg = wr_go & sel_cfg;
    assign wr_pll = wr_go & sel_pll;
    assign wr_ier = wr_go & sel_ier;
    assign wr_icr = wr_go & sel_icr;
    assign pll_locked = pll_on_r;

    // Ready and in-use conditions
    logic fx_rdy, rc_rdy, pll_rdy, sys_on_pll, fx_in_use, mon_active, fx_fail_evt, lx_fail_evt, xclk_edge;
    assign fx_rdy = fx_on_r & (settle_r == csp_pkg::SETTLE_DONE);
    assign rc_rdy = rc_on_r & st.fast_rc_ready;
    assign pll_rdy = pll_on_r & st.pll_lock_ready;
    assign sys_on_pll = sws_r == csp_pkg::SYS_PLL;
    assign fx_in_use = (sws_r == csp_pkg::SYS_FX) | (sys_on_pll & src_r);
    assign mon_active = mon_r & fx_rdy & ~fxf_r;
    assign fx_fail_evt = mon_active & st.fast_crystal_fail;
    assign lx_fail_evt = st.slow_crystal_fail;
    // Crystal edges seen through the synchroniser; crystal must stay at or below a quarter of the bus clock
    assign xclk_edge = st.fast_crystal_clk & ~xclk_prev_r;

    // Control bits with hardware overrides; Stop has the last word on the PLL, crystal and RC enables
    assign pll_on_nxt = stop_entry ? 1'b0 :
                        (fx_fail_evt & src_r) ? 1'b0 :
                        (wr_osc & (pwdata[csp_pkg::OSC_PLL_ON] | ~sys_on_pll)) ? pwdata[csp_pkg::OSC_PLL_ON] :
                        pll_on_r;
    assign fx_on_nxt = (stop_entry | fx_fail_evt) ? 1'b0 :
                       (wr_osc & ~(pwdata[csp_pkg::OSC_FX_ON] ? fxf_r : fx_in_use)) ? pwdata[csp_pkg::OSC_FX_ON] :
                       fx_on_r;
    // RC is the fallback on crystal failure, so hardware turns it on
    assign rc_on_nxt = stop_entry ? 1'b0 :
                       (fx_fail_evt & fx_in_use) ? 1'b1 :
                       (wr_osc & (pwdata[csp_pkg::OSC_RC_ON] | sws_r != csp_pkg::SYS_RC)) ? pwdata[csp_pkg::OSC_RC_ON] :
                       rc_on_r;
    assign mon_nxt = mon_r | (wr_osc & pwdata[csp_pkg::OSC_MON]);
    assign byp_nxt = (wr_osc & ~fx_on_r & ~fx_rdy) ? pwdata[csp_pkg::OSC_BYP] : byp_r;

    // System clock switch
    logic [2:0] sw_target;
    logic target_rdy;
    assign sw_target = (sw_r > csp_pkg::SYS_LX) ? csp_pkg::SYS_RC : sw_r;
    always_comb begin
        case (sw_target)
            csp_pkg::SYS_FX: target_rdy = fx_rdy;
            csp_pkg::SYS_PLL: target_rdy = pll_rdy;
            csp_pkg::SYS_LR: target_rdy = st.slow_rc_ready;
            csp_pkg::SYS_LX: target_rdy = st.slow_crystal_ready;
            default: target_rdy = rc_rdy;
        endcase
    end
    assign sws_nxt = (fx_fail_evt & fx_in_use) ? csp_pkg::SYS_RC :
                     (lx_fail_evt & sws_r == csp_pkg::SYS_LX) ? csp_pkg::SYS_LR :
                     target_rdy ? sw_target : sws_r;

    // Crystal settle counter
    logic [14:0] settle_last;
    always_comb begin
        case (settle_sel_r)
            2'h0: settle_last = 15'(SETTLE_CYC_0 - 1);
            2'h1: settle_last = 15'(SETTLE_CYC_1 - 1);
            2'h2: settle_last = 15'(SETTLE_CYC_2 - 1);
            default: settle_last = 15'(SETTLE_CYC_3 - 1);
        endcase
    end
    always_comb begin
        settle_nxt = settle_r;
        case (settle_r)
            csp_pkg::SETTLE_OFF: if (fx_on_r) settle_nxt = csp_pkg::SETTLE_COUNT;
            csp_pkg::SETTLE_COUNT: begin
                if (!fx_on_r) settle_nxt = csp_pkg::SETTLE_OFF;
                else if (xclk_edge && cnt_r == settle_last) settle_nxt = csp_pkg::SETTLE_DONE;
            end
            csp_pkg::SETTLE_DONE: if (!fx_on_r) settle_nxt = csp_pkg::SETTLE_OFF;
            default: settle_nxt = csp_pkg::SETTLE_OFF;
        endcase
    end

    // Ready flags: set beats a same-cycle clear
    logic [5:0] rdy_vec, rdy_clr;
    assign rdy_vec = {pll_rdy, fx_rdy, rc_rdy, 1'b0, st.slow_crystal_ready, st.slow_rc_ready};
    assign rdy_clr = wr_icr ? (pwdata[5:0] & csp_pkg::IER_MASK) : 6'h00;
    assign rdyf_nxt = (rdyf_r & ~rdy_clr) | (rdy_vec & ~rdy_prev_r & ier_r);

    // Read data
    logic [31:0] rd_osc, rd_cfg, rd_pll, rd_sel;
    assign rd_osc = {6'h0, pll_rdy, pll_on_r, 2'h0, drv_r, mon_r, fx_rdy, byp_r, fx_on_r,
                     3'h0, rcdiv_r, rc_rdy, awon_r, rc_on_r, 8'h00};
    assign rd_cfg = {1'b0, codiv_r, 1'b0, cosrc_r, 5'h00, apb2_r, 1'b0, apb1_r, 1'b0, ahb_r, 2'h0, sws_r, sw_r};
    assign rd_pll = {13'h0000, pdiv_r, gate_r, 5'h00, n_r, m_r, 2'h0, src_r};
    assign rd_sel = sel_osc ? rd_osc :
                    sel_stab ? {30'h0, settle_sel_r} :
                    sel_cfg ? rd_cfg :
                    sel_pll ? rd_pll :
                    sel_ier ? {26'h0, ier_r} :
                    sel_isr ? {22'h0, lxf_r, fxf_r, 2'h0, rdyf_r} : 32'h0000_0000;

    // APB slave: answer registered in setup, one wait-free access cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (setup & ~pwrite) ? rd_sel : 32'h0000_0000;
            pready <= setup;
            pslverr <= setup & ~mapped;
        end
    end

    // Oscillator control register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pll_on_r <= csp_pkg::OSC_RST[csp_pkg::OSC_PLL_ON];
            drv_r <= csp_pkg::OSC_RST[csp_pkg::OSC_DRV_LO +: 2];
            mon_r <= csp_pkg::OSC_RST[csp_pkg::OSC_MON];
            byp_r <= csp_pkg::OSC_RST[csp_pkg::OSC_BYP];
            fx_on_r <= csp_pkg::OSC_RST[csp_pkg::OSC_FX_ON];
            rcdiv_r <= csp_pkg::OSC_RST[csp_pkg::OSC_RCDIV_LO +: 2];
            awon_r <= csp_pkg::OSC_RST[csp_pkg::OSC_AWON];
            rc_on_r <= csp_pkg::OSC_RST[csp_pkg::OSC_RC_ON];
        end else begin
            pll_on_r <= pll_on_nxt;
            fx_on_r <= fx_on_nxt;
            rc_on_r <= rc_on_nxt;
            mon_r <= mon_nxt;
            byp_r <= byp_nxt;
            if (wr_osc) begin
                drv_r <= pwdata[csp_pkg::OSC_DRV_LO +: 2];
                rcdiv_r <= pwdata[csp_pkg::OSC_RCDIV_LO +: 2];
                awon_r <= pwdata[csp_pkg::OSC_AWON];
            end
        end
    end

    // Settle, configuration and PLL registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            settle_sel_r <= csp_pkg::STAB_RST[1:0];
            codiv_r <= csp_pkg::CFG_RST[csp_pkg::CFG_CODIV_LO +: 3];
            cosrc_r <= csp_pkg::CFG_RST[csp_pkg::CFG_COSRC_LO +: 3];
            apb2_r <= csp_pkg::CFG_RST[csp_pkg::CFG_APB2_LO +: 3];
            apb1_r <= csp_pkg::CFG_RST[csp_pkg::CFG_APB1_LO +: 3];
            ahb_r <= csp_pkg::CFG_RST[csp_pkg::CFG_AHB_LO +: 3];
            sws_r <= csp_pkg::CFG_RST[csp_pkg::CFG_SWS_LO +: 3];
            sw_r <= csp_pkg::CFG_RST[csp_pkg::CFG_SW_LO +: 3];
            pdiv_r <= csp_pkg::PLL_RST[csp_pkg::PLL_DIV_LO +: 2];
            gate_r <= csp_pkg::PLL_RST[csp_pkg::PLL_GATE];
            n_r <= csp_pkg::PLL_RST[csp_pkg::PLL_N_LO +: 3];
            m_r <= csp_pkg::PLL_RST[csp_pkg::PLL_M_LO +: 5];
            src_r <= csp_pkg::PLL_RST[csp_pkg::PLL_SRC];
        end else begin
            if (wr_stab && !fx_on_r) settle_sel_r <= pwdata[1:0];
            if (wr_cfg) begin
                codiv_r <= pwdata[csp_pkg::CFG_CODIV_LO +: 3];
                cosrc_r <= pwdata[csp_pkg::CFG_COSRC_LO +: 3];
                apb2_r <= pwdata[csp_pkg::CFG_APB2_LO +: 3];
                apb1_r <= pwdata[csp_pkg::CFG_APB1_LO +: 3];
                ahb_r <= pwdata[csp_pkg::CFG_AHB_LO +: 3];
                sw_r <= pwdata[csp_pkg::CFG_SW_LO +: 3];
            end
            sws_r <= sws_nxt;
            if (stop_entry) gate_r <= 1'b0;
            else if (wr_pll) gate_r <= pwdata[csp_pkg::PLL_GATE];
            if (wr_pll && !pll_locked) begin
                pdiv_r <= pwdata[csp_pkg::PLL_DIV_LO +: 2];
                n_r <= pwdata[csp_pkg::PLL_N_LO +: 3];
                m_r <= pwdata[csp_pkg::PLL_M_LO +: 5];
                src_r <= pwdata[csp_pkg::PLL_SRC];
            end
        end
    end

    // Interrupt enables, flags, settle state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ier_r <= csp_pkg::IER_RST[5:0];
            rdyf_r <= 6'h00;
            rdy_prev_r <= 6'h00;
            fxf_r <= 1'b0;
            lxf_r <= 1'b0;
            settle_r <= csp_pkg::SETTLE_OFF;
            cnt_r <= 15'h0000;
            xclk_prev_r <= 1'b0;
        end else begin
            if (wr_ier) ier_r <= pwdata[5:0] & csp_pkg::IER_MASK;
            rdyf_r <= rdyf_nxt;
            rdy_prev_r <= rdy_vec;
            fxf_r <= fx_fail_evt | (fxf_r & ~(wr_icr & pwdata[csp_pkg::FAIL_FX]));
            lxf_r <= lx_fail_evt | (lxf_r & ~(wr_icr & pwdata[csp_pkg::FAIL_LX]));
            settle_r <= settle_nxt;
            xclk_prev_r <= st.fast_crystal_clk;
            if (settle_r != csp_pkg::SETTLE_COUNT) cnt_r <= 15'h0000;
            else if (xclk_edge) cnt_r <= cnt_r + 15'h0001;
        end
    end

    // Registered outputs toward the clock tree
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            osc_ctrl <= '0;
            clk_cfg <= '0;
        end else begin
            osc_ctrl.fast_crystal_enable <= fx_on_r;
            osc_ctrl.fast_crystal_bypass <= byp_r;
            osc_ctrl.fast_crystal_drive <= drv_r;
            osc_ctrl.fast_crystal_monitor_active <= mon_active;
            osc_ctrl.fast_rc_run <= rc_on_r | awon_r;
            osc_ctrl.pll_power_enable <= pll_on_r;
            osc_ctrl.pll_output_gate <= gate_r;
            osc_ctrl.pll_source_select <= src_r;
            clk_cfg.fast_rc_div <= 4'h1 << rcdiv_r;
            clk_cfg.ahb_div <= 8'h01 << ahb_r;
            clk_cfg.apb1_div <= apb1_r[2] ? (5'h02 << apb1_r[1:0]) : 5'h01;
            clk_cfg.apb2_div <= apb2_r[2] ? (5'h02 << apb2_r[1:0]) : 5'h01;
            clk_cfg.clock_out_div <= 8'h01 << codiv_r;
            clk_cfg.clock_out_source <= (cosrc_r == csp_pkg::CO_RESERVED) ? 3'h0 : cosrc_r;
            clk_cfg.system_clock_source <= sws_r;
            clk_cfg.pll_input_div <= (n_r == 3'h0) ? 4'h8 : {1'b0, n_r};
            clk_cfg.pll_mult <= (m_r == 5'h00) ? 6'h20 : {1'b0, m_r};
            clk_cfg.pll_post_div <= 4'h1 << pdiv_r;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_stop_pll;
        stop_entry |=> !pll_on_r && !gate_r;
    endproperty
    a_stop_pll: assert property (p_stop_pll) else $error("PLL enable survived stop");
    property p_pll_in_use;
        wr_osc && !pwdata[csp_pkg::OSC_PLL_ON] && sys_on_pll && !stop_entry && !(fx_fail_evt && src_r) |=> pll_on_r;
    endproperty
    a_pll_in_use: assert property (p_pll_in_use) else $error("In-use PLL was disabled");
    property p_mon_sticky;
        mon_r |=> mon_r;
    endproperty
    a_mon_sticky: assert property (p_mon_sticky) else $error("Monitor enable cleared");
    property p_ready_off;
        !fx_on_r |-> !fx_rdy ##1 !osc_ctrl.fast_crystal_monitor_active;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("Crystal ready without enable");
    property p_bypass_lock;
        wr_osc && (fx_on_r || fx_rdy) |=> $stable(byp_r);
    endproperty
    a_bypass_lock: assert property (p_bypass_lock) else $error("Bypass changed while crystal on");
    property p_stop_osc;
        stop_entry |=> !fx_on_r && !rc_on_r ##1 !osc_ctrl.fast_crystal_enable;
    endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("Oscillator survived stop");
    property p_rc_div;
        wr_osc |-> ##2 clk_cfg.fast_rc_div == (4'h1 << $past(pwdata[csp_pkg::OSC_RCDIV_LO +: 2], 2));
    endproperty
    a_rc_div: assert property (p_rc_div) else $error("RC divide factor wrong");
    property p_settle_lock;
        fx_on_r |=> $stable(settle_sel_r);
    endproperty
    a_settle_lock: assert property (p_settle_lock) else $error("Settle count changed while on");
    property p_pll_fields;
        pll_on_r |=> $stable({pdiv_r, n_r, m_r, src_r});
    endproperty
    a_pll_fields: assert property (p_pll_fields) else $error("PLL field written while on");
    property p_switch_ready;
        $changed(sws_r) && !$past(fx_fail_evt) && !$past(lx_fail_evt) |-> $past(target_rdy);
    endproperty
    a_switch_ready: assert property (p_switch_ready) else $error("Switched to unready source");
    property p_flag_set;
        rdy_vec[csp_pkg::IRQ_RC] && !rdy_prev_r[csp_pkg::IRQ_RC] && ier_r[csp_pkg::IRQ_RC] |=> rdyf_r[csp_pkg::IRQ_RC];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Ready flag not set");

    c_pll_sys: cover property (sws_r == csp_pkg::SYS_PLL);
    c_fx_fail: cover property (fx_fail_evt ##1 fxf_r);
    c_flag_clear: cover property (rdyf_r[csp_pkg::IRQ_FX] ##1 !rdyf_r[csp_pkg::IRQ_FX]);
    c_settled: cover property (settle_r == csp_pkg::SETTLE_DONE);
endmodule
`default_nettype wire

// ==== pkg/csp_pkg.sv ====
`default_nettype none
package csp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_OSC = 8'h00;
    localparam logic [7:0] OFF_STAB = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_PLL = 8'h0c;
    localparam logic [7:0] OFF_IER = 8'h10;
    localparam logic [7:0] OFF_ISR = 8'h14;
    localparam logic [7:0] OFF_ICR = 8'h18;

    // Reset values
    localparam logic [31:0] OSC_RST = 32'h0000_0100;
    localparam logic [31:0] STAB_RST = 32'h0000_0003;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PLL_RST = 32'h0002_0260;
    localparam logic [31:0] IER_RST = 32'h0000_0000;
    localparam logic [5:0] IER_MASK = 6'h3b;

    // oscillator_control fields
    localparam int OSC_PLL_ON = 24;
    localparam int OSC_DRV_LO = 20;
    localparam int OSC_MON = 19;
    localparam int OSC_BYP = 17;
    localparam int OSC_FX_ON = 16;
    localparam int OSC_RCDIV_LO = 11;
    localparam int OSC_AWON = 9;
    localparam int OSC_RC_ON = 8;
    // clock_select_prescale fields
    localparam int CFG_CODIV_LO = 28;
    localparam int CFG_COSRC_LO = 24;
    localparam int CFG_APB2_LO = 16;
    localparam int CFG_APB1_LO = 12;
    localparam int CFG_AHB_LO = 8;
    localparam int CFG_SWS_LO = 3;
    localparam int CFG_SW_LO = 0;
    // pll_config fields
    localparam int PLL_DIV_LO = 17;
    localparam int PLL_GATE = 16;
    localparam int PLL_N_LO = 8;
    localparam int PLL_M_LO = 3;
    localparam int PLL_SRC = 0;
    // Flag bits in clock_irq_flags / clear register
    localparam int IRQ_PLL = 5;
    localparam int IRQ_FX = 4;
    localparam int IRQ_RC = 3;
    localparam int IRQ_LX = 1;
    localparam int IRQ_LR = 0;
    localparam int FAIL_FX = 8;
    localparam int FAIL_LX = 9;

    // System clock source codes, plus the reserved clock-out source code
    localparam logic [2:0] SYS_RC = 3'h0;
    localparam logic [2:0] SYS_FX = 3'h1;
    localparam logic [2:0] SYS_PLL = 3'h2;
    localparam logic [2:0] SYS_LR = 3'h3;
    localparam logic [2:0] SYS_LX = 3'h4;
    localparam logic [2:0] CO_RESERVED = 3'h2;

    // Crystal settle counts, in crystal cycles
    localparam int unsigned SETTLE_CYC_0 = 256;
    localparam int unsigned SETTLE_CYC_1 = 1024;
    localparam int unsigned SETTLE_CYC_2 = 4096;
    localparam int unsigned SETTLE_CYC_3 = 16384;

    typedef enum logic [1:0] {SETTLE_OFF, SETTLE_COUNT, SETTLE_DONE} csp_settle_type;

    typedef struct packed {
        logic fast_crystal_clk;
        logic fast_rc_ready;
        logic pll_lock_ready;
        logic slow_rc_ready;
        logic slow_crystal_ready;
        logic fast_crystal_fail;
        logic slow_crystal_fail;
    } csp_osc_stat_type;

    typedef struct packed {
        logic fast_crystal_enable;
        logic fast_crystal_bypass;
        logic [1:0] fast_crystal_drive;
        logic fast_crystal_monitor_active;
        logic fast_rc_run;
        logic pll_power_enable;
        logic pll_output_gate;
        logic pll_source_select;
    } csp_osc_ctrl_type;

    typedef struct packed {
        logic [3:0] fast_rc_div;
        logic [7:0] ahb_div;
        logic [4:0] apb1_div;
        logic [4:0] apb2_div;
        logic [7:0] clock_out_div;
        logic [2:0] clock_out_source;
        logic [2:0] system_clock_source;
        logic [3:0] pll_input_div;
        logic [5:0] pll_mult;
        logic [3:0] pll_post_div;
    } csp_clk_cfg_type;
endpackage
`default_nettype wire

// ==== hw/csp_sync3.sv ====
`default_nettype none
// Three-stage synchroniser; a bit moves only once stages two and three agree
module csp_sync3 #(
    parameter int WIDTH = 7
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] agree;

    assign agree = s2_r ~^ s3_r;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= (agree & s3_r) | (~agree & dout);
        end
    end
endmodule
`default_nettype wire

// ==== dv/clock_source_and_pll_control_test.sv ====
`default_nettype none
module clock_source_and_pll_control_test;
timeunit 1ns;
timeprecision 1ns;
typedef struct packed {logic c; logic e; logic [31:0] d;} csp_note_type;
localparam logic [7:0] a_osc = csp_pkg::OFF_OSC;
localparam logic [7:0] a_stab = csp_pkg::OFF_STAB;
localparam logic [7:0] a_cfg = csp_pkg::OFF_CFG;
localparam logic [7:0] a_pll = csp_pkg::OFF_PLL;
localparam logic [7:0] a_isr = csp_pkg::OFF_ISR;
localparam logic [7:0] a_icr = csp_pkg::OFF_ICR;
logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_entry = 1'b0;
logic pready, pslverr;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0000_0000, prdata, last_rd, v;
csp_pkg::csp_osc_stat_type osc_status = '0;
csp_pkg::csp_osc_ctrl_type osc_ctrl;
csp_pkg::csp_clk_cfg_type clk_cfg;
int fail_count = 0, checks_done = 0, seed = 32'h7f65, n;
csp_note_type q[$], nt;
always #50 clock = ~clock;
// Short settle counts keep the crystal start-up to a few dozen clocks
csp_ctrl #(.SETTLE_CYC_0(4), .SETTLE_CYC_1(8), .SETTLE_CYC_2(16), .SETTLE_CYC_3(32)) i_dut (.clock(clock),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_entry(stop_entry), .osc_status(osc_status),
    .osc_ctrl(osc_ctrl), .clk_cfg(clk_cfg));
// Crystal at clock/8, well under the synchroniser limit
always begin
    repeat (4) @(posedge clock);
    osc_status.fast_crystal_clk <= ~osc_status.fast_crystal_clk;
end
task check(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
        fail_count++;
        $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
endtask
task conclude;
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c, input logic [31:0] e);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back('{c, a > 8'h18 || a[1:0] != 2'h0, e});
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
        @(posedge clock);
        k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
        fail_count++;
        conclude();
    end
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0000_0000);
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 1'b1, e);
endtask
task stop_pulse;
    @(posedge clock);
    stop_entry <= 1'b1;
    @(posedge clock);
    stop_entry <= 1'b0;
endtask
always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
        nt = q.pop_front();
        last_rd <= prdata;
        if (nt.c) check(prdata, nt.d);
        check({31'h0, pslverr}, {31'h0, nt.e});
    end
end
initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
end
initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rd(a_stab, 32'h0000_0003);
    rd(a_pll, 32'h0002_0260);
    rd(a_osc, 32'h0000_0100);
    rd(a_cfg, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    wr(a_isr, 32'hffff_ffff);
    rd(a_isr, 32'h0000_0000);
    for (n = 0; n < 4; n++) begin
        v = $random(seed);
        wr(csp_pkg::OFF_IER, v);
        rd(csp_pkg::OFF_IER, v & 32'h0000_003b);
        v = $random(seed) & 32'h7707_7707;
        wr(a_cfg, v);
        rd(a_cfg, v);
        check({24'h0, clk_cfg.ahb_div}, 32'h1 << v[10:8]);
        check({27'h0, clk_cfg.apb1_div}, v[14] ? 32'h2 << v[13:12] : 32'h1);
        check({27'h0, clk_cfg.apb2_div}, v[18] ? 32'h2 << v[17:16] : 32'h1);
        check({24'h0, clk_cfg.clock_out_div}, 32'h1 << v[30:28]);
        check({29'h0, clk_cfg.clock_out_source}, {29'h0, v[26:24] == 3'h2 ? 3'h0 : v[26:24]});
        check({29'h0, clk_cfg.system_clock_source}, 32'h0);
        v = $random(seed) & 32'h0006_07f9;
        wr(a_pll, v);
        rd(a_pll, v);
        check({28'h0, clk_cfg.pll_input_div}, v[10:8] == 3'h0 ? 32'h8 : {29'h0, v[10:8]});
        check({26'h0, clk_cfg.pll_mult}, v[7:3] == 5'h0 ? 32'h20 : {27'h0, v[7:3]});
        check({28'h0, clk_cfg.pll_post_div}, 32'h1 << v[18:17]);
    end
    wr(a_cfg, 32'h0000_0000);
    wr(a_pll, v | 32'h0001_0000);
    wr(a_osc, 32'h0100_0100);
    // Gate bit stays writable while the PLL runs, so keep it set here
    wr(a_pll, (v ^ 32'h0006_0709) | 32'h0001_0000);
    rd(a_pll, v | 32'h0001_0000);
    stop_pulse();
    rd(a_osc, 32'h0000_0000);
    rd(a_pll, v);
    wr(a_osc, 32'h0000_1b00);
    stop_pulse();
    rd(a_osc, 32'h0000_1a00);
    check({31'h0, osc_ctrl.fast_rc_run}, 32'h1);
    check({28'h0, clk_cfg.fast_rc_div}, 32'h8);
    wr(csp_pkg::OFF_IER, 32'h0000_0010);
    wr(a_osc, 32'h0002_0100);
    rd(a_osc, 32'h0002_0100);
    wr(a_stab, 32'h0000_0000);
    wr(a_osc, 32'h003b_0100);
    wr(a_stab, 32'h0000_0003);
    rd(a_stab, 32'h0000_0000);
    check({30'h0, osc_ctrl.fast_crystal_drive}, 32'h3);
    n = 0;
    do begin
        apb(1'b0, a_osc, 32'h0000_0000, 1'b0, 32'h0000_0000);
        @(posedge clock);
        n++;
    end while (last_rd[18] !== 1'b1 && n < 50);
    if (last_rd[18] !== 1'b1) begin
        fail_count++;
        conclude();
    end
    check({31'h0, osc_ctrl.fast_crystal_monitor_active}, 32'h1);
    rd(a_isr, 32'h0000_0010);
    wr(a_icr, 32'h0000_0010);
    rd(a_isr, 32'h0000_0000);
    wr(a_osc, 32'h0001_0100);
    rd(a_osc, 32'h000f_0100);
    wr(a_osc, 32'h0000_0100);
    rd(a_osc, 32'h000a_0100);
    @(posedge clock);
    osc_status.slow_crystal_fail <= 1'b1;
    repeat (3) @(posedge clock);
    osc_status.slow_crystal_fail <= 1'b0;
    repeat (6) @(posedge clock);
    rd(a_isr, 32'h0000_0200);
    wr(a_icr, 32'h0000_0200);
    rd(a_isr, 32'h0000_0000);
    // RC and PLL come ready, then the system clock moves onto the PLL
    wr(csp_pkg::OFF_IER, 32'h0000_0028);
    osc_status.fast_rc_ready <= 1'b1;
    osc_status.pll_lock_ready <= 1'b1;
    wr(a_osc, 32'h0100_0100);
    wr(a_pll, v | 32'h0001_0000);
    wr(a_cfg, 32'h0000_0002);
    rd(a_cfg, 32'h0000_0012);
    check({29'h0, clk_cfg.system_clock_source}, 32'h0000_0002);
    wr(a_osc, 32'h0000_0100);
    rd(a_osc, 32'h0308_0500);
    rd(a_isr, 32'h0000_0028);
    check({23'h0, osc_ctrl}, {28'h000_0000, 3'h7, v[0]});
    conclude();
end
endmodule
`default_nettype wire
